// *** core/byte_alu_pkg.sv ***
package byte_alu_pkg;

   // ==========================================================
   // Widths
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PADDR_W = 12;
   localparam int MEM_DEPTH = 128;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [11:0] REG_INSTR = 12'h000;
   localparam logic [11:0] REG_WORK = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_FILE_ADDR = 12'h00c;
   localparam logic [11:0] REG_FILE_DATA = 12'h010;

   // ==========================================================
   // Field positions
   localparam int INSTR_OP_LSB = 0;
   localparam int INSTR_DEST_BIT = 8;
   localparam int INSTR_ADDR_LSB = 16;
   localparam int STATUS_C_BIT = 0;
   localparam int STATUS_Z_BIT = 1;

   // ==========================================================
   // Reset values and constants
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic [6:0] FILE_ADDR_RESET = 7'h00;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic DEST_WORK = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic [7:0] ONE = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ==========================================================
   // Operation codes
   typedef enum logic [2:0] {
      op_increment_reg = 3'b000,
      op_or_work_with_reg = 3'b001,
      op_shift_left_logical = 3'b010,
      op_shift_right_logical = 3'b011,
      op_move_reg = 3'b100
   } op_t;

   // Register select, also the pending write kind
   typedef enum logic [2:0] {
      sel_none = 3'b000,
      sel_instr = 3'b001,
      sel_work = 3'b010,
      sel_status = 3'b011,
      sel_faddr = 3'b100,
      sel_fdata = 3'b101
   } sel_t;

   // Bus slave states
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_operand = 2'b01,
      st_mem_wait = 2'b10,
      st_resp = 2'b11
   } fsm_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic [7:0] result;
      logic carry;
      logic zero;
      logic carry_upd;
   } alu_out_t;

endpackage : byte_alu_pkg

// *** core/byte_file_mem.sv ***
// ==========================================================
// Data memory, 128 bytes, registered read data
module byte_file_mem
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Access port
   input wire logic [6:0] i_addr,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   import byte_alu_pkg::*;

   logic [7:0] mem [MEM_DEPTH];

   // Array write
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end

   // Read data register, old contents on a write
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= ZERO_BYTE;
      end else begin
         o_rdata <= mem[i_addr];
      end
   end

endmodule : byte_file_mem

// *** core/byte_alu.sv ***
// ==========================================================
// Combinational byte operation unit
module byte_alu
(
   // Operands
   input wire byte_alu_pkg::op_t i_op,
   input wire logic [7:0] i_work,
   input wire logic [7:0] i_operand,
   input wire logic i_carry,
   // Result
   output byte_alu_pkg::alu_out_t o_alu
);
   import byte_alu_pkg::*;

   // Result, carry and zero per operation
   always_comb begin
      o_alu.carry = i_carry;
      o_alu.carry_upd = 1'b0;
      unique case (i_op)
         op_increment_reg: begin
            o_alu.result = i_operand + ONE;
         end
         op_or_work_with_reg: begin
            o_alu.result = i_work | i_operand;
         end
         op_shift_left_logical: begin
            o_alu.result = {i_operand[6:0], 1'b0};
            o_alu.carry = i_operand[7];
            o_alu.carry_upd = 1'b1;
         end
         op_shift_right_logical: begin
            o_alu.result = {1'b0, i_operand[7:1]};
            o_alu.carry = i_operand[0];
            o_alu.carry_upd = 1'b1;
         end
         op_move_reg: begin
            o_alu.result = i_operand;
         end
         default: begin
            o_alu.result = i_operand;
         end
      endcase
      o_alu.zero = (o_alu.result == ZERO_BYTE);
   end

endmodule : byte_alu

// *** core/byte_alu_inc_or_shift_move.sv ***
// Functional notes
// - Increment adds one to the addressed byte, result to the destination, only Z updated.
// - Destination bit 0 writes the working register, 1 writes back the source register.
// - The register address operand spans 0 to 127 and the destination is a single bit.
// - Inclusive OR of working and addressed byte goes to the destination, only Z updated.
// - Left shift moves bit 7 to carry, bits 6:0 up one, clears bit 0, and updates C and Z.
// - Right shift clears bit 7, moves bits 7:1 down one, bit 0 to carry, updates C and Z.
// - Move copies the byte to the destination and updates Z; write back makes it a test.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module byte_alu_inc_or_shift_move
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // APB slave
   input wire byte_alu_pkg::apb_req_t i_apb,
   output byte_alu_pkg::apb_rsp_t o_apb,
   // Core state
   output logic [7:0] o_wreg,
   output logic o_carry,
   output logic o_zero
);
   import byte_alu_pkg::*;

   // ==========================================================
   // State

   typedef struct packed {
      fsm_t fsm;
      sel_t pend;
      apb_rsp_t rsp;
      logic [7:0] wreg;
      logic carry;
      logic zero;
      logic [6:0] file_addr;
      op_t op;
      logic dest;
      logic [6:0] op_addr;
      logic [7:0] operand;
      alu_out_t alu;
      logic [31:0] wdata;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [6:0] mem_addr;
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;
   alu_out_t alu_o;
   logic [31:0] instr_view;
   logic [31:0] status_view;

   // Address decode of the register map
   function automatic sel_t reg_decode(input logic [11:0] addr);
      unique case (addr)
         REG_INSTR: reg_decode = sel_instr;
         REG_WORK: reg_decode = sel_work;
         REG_STATUS: reg_decode = sel_status;
         REG_FILE_ADDR: reg_decode = sel_faddr;
         REG_FILE_DATA: reg_decode = sel_fdata;
         default: reg_decode = sel_none;
      endcase
   endfunction : reg_decode

   // Legal operation code check
   function automatic logic op_legal(input logic [2:0] code);
      op_legal = (code <= op_move_reg);
   endfunction : op_legal

   // ==========================================================
   // Submodules

   // Data memory holding the file registers
   byte_file_mem u_mem (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_addr(mem_addr),
      .i_we(mem_we),
      .i_wdata(mem_wdata),
      .o_rdata(mem_rdata)
   );

   // Operation unit fed by the fetched operand
   byte_alu u_alu (
      .i_op(s_q.op),
      .i_work(s_q.wreg),
      .i_operand(mem_rdata),
      .i_carry(s_q.carry),
      .o_alu(alu_o)
   );

   // ==========================================================
   // Read views

   // Last instruction and status as seen by software
   always_comb begin
      instr_view = '0;
      instr_view[INSTR_OP_LSB +: 3] = s_q.op;
      instr_view[INSTR_DEST_BIT] = s_q.dest;
      instr_view[INSTR_ADDR_LSB +: FADDR_W] = s_q.op_addr;
      status_view = '0;
      status_view[STATUS_C_BIT] = s_q.carry;
      status_view[STATUS_Z_BIT] = s_q.zero;
   end

   // ==========================================================
   // Next state

   // Bus handshake, operand fetch and commit at the answering edge
   always_comb begin
      s_d = s_q;
      mem_we = 1'b0;
      mem_addr = s_q.file_addr;
      mem_wdata = s_q.wdata[7:0];
      unique case (s_q.fsm)
         st_idle: begin
            if (i_apb.psel && i_apb.penable) begin
               s_d.wdata = i_apb.pwdata;
               s_d.rsp.prdata = '0;
               s_d.rsp.pslverr = 1'b0;
               s_d.rsp.pready = 1'b1;
               s_d.fsm = st_resp;
               s_d.pend = i_apb.pwrite ? reg_decode(i_apb.paddr) : sel_none;
               unique case (reg_decode(i_apb.paddr))
                  sel_instr: begin
                     if (!i_apb.pwrite) begin
                        s_d.rsp.prdata = instr_view;
                     end else if (op_legal(i_apb.pwdata[INSTR_OP_LSB +: 3])) begin
                        // Fetch the operand; answer follows one cycle later
                        s_d.op = op_t'(i_apb.pwdata[INSTR_OP_LSB +: 3]);
                        s_d.dest = i_apb.pwdata[INSTR_DEST_BIT];
                        s_d.op_addr = i_apb.pwdata[INSTR_ADDR_LSB +: FADDR_W];
                        mem_addr = i_apb.pwdata[INSTR_ADDR_LSB +: FADDR_W];
                        s_d.rsp.pready = 1'b0;
                        s_d.fsm = st_operand;
                     end else begin
                        s_d.rsp.pslverr = 1'b1;
                        s_d.pend = sel_none;
                     end
                  end
                  sel_work: begin
                     s_d.rsp.prdata = {24'h000000, s_q.wreg};
                  end
                  sel_status: begin
                     s_d.rsp.prdata = status_view;
                  end
                  sel_faddr: begin
                     s_d.rsp.prdata = {25'h0, s_q.file_addr};
                  end
                  sel_fdata: begin
                     if (!i_apb.pwrite) begin
                        s_d.rsp.pready = 1'b0;
                        s_d.fsm = st_mem_wait;
                     end
                  end
                  default: begin
                     s_d.rsp.pslverr = 1'b1;
                  end
               endcase
            end
         end
         st_operand: begin
            // Operand is on the memory output now
            s_d.operand = mem_rdata;
            s_d.alu = alu_o;
            s_d.rsp.pready = 1'b1;
            s_d.fsm = st_resp;
         end
         st_mem_wait: begin
            s_d.rsp.prdata = {24'h000000, mem_rdata};
            s_d.rsp.pready = 1'b1;
            s_d.fsm = st_resp;
         end
         st_resp: begin
            s_d.rsp.pready = 1'b0;
            s_d.pend = sel_none;
            s_d.fsm = st_idle;
            unique case (s_q.pend)
               sel_instr: begin
                  if (s_q.dest == DEST_FILE) begin
                     mem_we = 1'b1;
                     mem_addr = s_q.op_addr;
                     mem_wdata = s_q.alu.result;
                  end else begin
                     s_d.wreg = s_q.alu.result;
                  end
                  s_d.zero = s_q.alu.zero;
                  if (s_q.alu.carry_upd) begin
                     s_d.carry = s_q.alu.carry;
                  end
               end
               sel_work: begin
                  s_d.wreg = s_q.wdata[7:0];
               end
               sel_status: begin
                  s_d.carry = s_q.wdata[STATUS_C_BIT];
                  s_d.zero = s_q.wdata[STATUS_Z_BIT];
               end
               sel_faddr: begin
                  s_d.file_addr = s_q.wdata[6:0];
               end
               sel_fdata: begin
                  mem_we = 1'b1;
               end
               default: begin
               end
            endcase
         end
      endcase
   end

   // ==========================================================
   // State register

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
         s_q.wreg <= WORK_RESET;
         s_q.carry <= FLAG_RESET;
         s_q.zero <= FLAG_RESET;
         s_q.file_addr <= FILE_ADDR_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign o_apb = s_q.rsp;
   assign o_wreg = s_q.wreg;
   assign o_carry = s_q.carry;
   assign o_zero = s_q.zero;

   // ==========================================================
   // Assertions

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   logic commit_op;
   logic to_work;
   assign commit_op = (s_q.fsm == st_resp) && (s_q.pend == sel_instr);
   assign to_work = commit_op && (s_q.dest == DEST_WORK);

   property p_inc_result;
      to_work && (s_q.op == op_increment_reg)
         |=> (o_wreg == 8'($past(s_q.operand) + ONE)) && $stable(o_carry);
   endproperty
   a_inc_result: assert property (p_inc_result) else $error("increment result wrong");

   property p_dest_file;
      commit_op && (s_q.dest == DEST_FILE)
         |-> mem_we && (mem_addr == s_q.op_addr) ##1 $stable(o_wreg);
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("write back to file failed");

   property p_dest_work;
      to_work |-> !mem_we;
   endproperty
   a_dest_work: assert property (p_dest_work) else $error("file written for work dest");

   // Operand fetch used the address field of the accepted word
   property p_addr_taken;
      (s_q.fsm == st_idle) ##1 (s_q.fsm == st_operand)
         |-> (s_q.op_addr == $past(i_apb.pwdata[INSTR_ADDR_LSB +: FADDR_W]))
         && ($past(mem_addr) == s_q.op_addr);
   endproperty
   a_addr_taken: assert property (p_addr_taken) else $error("operand address lost");

   property p_or_result;
      to_work && (s_q.op == op_or_work_with_reg)
         |=> (o_wreg == ($past(o_wreg) | $past(s_q.operand))) && $stable(o_carry);
   endproperty
   a_or_result: assert property (p_or_result) else $error("or result wrong");

   property p_shl;
      to_work && (s_q.op == op_shift_left_logical)
         |=> (o_carry == $past(s_q.operand[7])) && (o_wreg[0] == 1'b0)
         && (o_wreg[7:1] == $past(s_q.operand[6:0]));
   endproperty
   a_shl: assert property (p_shl) else $error("left shift wrong");

   property p_shr;
      to_work && (s_q.op == op_shift_right_logical)
         |=> (o_carry == $past(s_q.operand[0])) && (o_wreg[7] == 1'b0)
         && (o_wreg[6:0] == $past(s_q.operand[7:1]));
   endproperty
   a_shr: assert property (p_shr) else $error("right shift wrong");

   property p_mov_test;
      commit_op && (s_q.op == op_move_reg)
         |=> (o_zero == ($past(s_q.operand) == ZERO_BYTE));
   endproperty
   a_mov_test: assert property (p_mov_test) else $error("move zero flag wrong");

   property p_zero_flag;
      to_work |=> (o_zero == (o_wreg == ZERO_BYTE));
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag mismatch");

   property p_one_cycle;
      (s_q.fsm == st_operand) |=> o_apb.pready ##1 (s_q.fsm == st_idle) && !o_apb.pready;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("operation not single cycle");

   c_inc_file: cover property (commit_op && s_q.op == op_increment_reg && s_q.dest == DEST_FILE);
   c_shl_carry: cover property (to_work && s_q.op == op_shift_left_logical && s_q.operand[7]);
   c_mov_zero: cover property (commit_op && s_q.op == op_move_reg && s_q.operand == ZERO_BYTE);
   c_slverr: cover property (o_apb.pready && o_apb.pslverr);

endmodule : byte_alu_inc_or_shift_move

// *** bench/tb.sv ***
// ==========================================================
// Self-checking bench for the byte operation datapath
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import byte_alu_pkg::*;

   logic i_clk;
   logic i_rstn;
   apb_req_t i_apb;
   apb_rsp_t o_apb;
   logic [7:0] o_wreg;
   logic o_carry;
   logic o_zero;
   int n_mismatch;
   int n_tests;
   int mem [128];
   int w;
   int c;
   int z;
   logic [31:0] last_instr;
   logic [31:0] rd;
   logic err;

   byte_alu_inc_or_shift_move byte_alu_inc_or_shift_move_inst (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_apb(i_apb),
      .o_apb(o_apb),
      .o_wreg(o_wreg),
      .o_carry(o_carry),
      .o_zero(o_zero)
   );

   // Clock, 100 ns period
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // ==========================================================
   // Reporting
   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // Compare a bus word
   task automatic chk_bus(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask : chk_bus

   // Compare core state held on the outputs
   task automatic chk_core(input string name, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask : chk_core

   // ==========================================================
   // APB master; entered just after a rising edge, leaves one idle cycle
   task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
      int k;
      i_apb.paddr <= a;
      i_apb.psel <= 1'b1;
      i_apb.penable <= 1'b0;
      i_apb.pwrite <= wr;
      i_apb.pwdata <= d;
      @(posedge i_clk);
      i_apb.penable <= 1'b1;
      k = 0;
      // Outputs are read at the rising edge, before the design updates them
      do begin
         @(posedge i_clk);
         k++;
      end while (o_apb.pready !== 1'b1 && k < 50);
      if (o_apb.pready !== 1'b1) begin
         n_mismatch++;
         $display("unexpected pready: expected 1, seen %b", o_apb.pready);
         stop_test();
      end
      rd = o_apb.prdata;
      err = o_apb.pslverr;
      i_apb.psel <= 1'b0;
      i_apb.penable <= 1'b0;
      @(posedge i_clk);
   endtask : apb

   // Plain register write that must be accepted
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
      chk_bus("write_err", 32'h0, {31'h0, err});
   endtask : wr

   // Register read compared with an expected word
   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk_bus("read_err", 32'h0, {31'h0, err});
      chk_bus(name, e, rd);
   endtask : rd_chk

   // Reset held ten cycles, outputs checked while held
   task automatic rst;
      i_rstn <= 1'b0;
      repeat (10) @(posedge i_clk);
      chk_core("reset_wreg", 8'h00, o_wreg);
      chk_core("reset_flags", 8'h00, {6'h0, o_zero, o_carry});
      chk_bus("reset_pready", 32'h0, {31'h0, o_apb.pready});
      w = 0;
      c = 0;
      z = 0;
      last_instr = 32'h0;
      i_rstn <= 1'b1;
   endtask : rst

   // ==========================================================
   // One operation through the INSTR register, against the model
   task automatic exec(input int op, input int dest, input int f);
      logic [31:0] word;
      int v;
      int r;
      word = {9'h0, 7'(f), 7'h0, 1'(dest), 5'h0, 3'(op)};
      apb(REG_INSTR, 1'b1, word);
      v = mem[f];
      r = v;
      case (op)
         0: r = (v + 1) & 255;
         1: r = w | v;
         2: begin
            r = (v << 1) & 255;
            c = v >> 7;
         end
         3: begin
            r = v >> 1;
            c = v & 1;
         end
         default: r = v;
      endcase
      if (op > 4) begin
         chk_bus("illegal_op_err", 32'h1, {31'h0, err});
      end else begin
         chk_bus("op_err", 32'h0, {31'h0, err});
         last_instr = word;
         z = (r == 0) ? 1 : 0;
         if (dest == 1) begin
            mem[f] = r;
         end else begin
            w = r;
         end
      end
      chk_core("wreg", 8'(w), o_wreg);
      chk_core("carry", 8'(c), {7'h0, o_carry});
      chk_core("zero", 8'(z), {7'h0, o_zero});
   endtask : exec

   // ==========================================================
   // Main sequence
   initial begin
      int f;
      int v;
      int st;
      i_apb = '0;
      i_rstn = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      void'($urandom(32'hc59a));
      rst();
      // Plain register access and refused addresses
      wr(REG_WORK, 32'h0000_00a5);
      rd_chk("work", REG_WORK, 32'h0000_00a5);
      wr(REG_STATUS, 32'h0000_0003);
      rd_chk("status", REG_STATUS, 32'h0000_0003);
      foreach (mem[i]) mem[i] = 0;
      // The unaligned access is a write and must leave every register alone
      for (int i = 0; i < 3; i++) begin
         apb((i == 0) ? 12'h014 : (i == 1) ? 12'h002 : 12'hffc, (i == 1), 32'hffff_ffff);
         chk_bus("unmapped_err", 32'h1, {31'h0, err});
         chk_bus("unmapped_data", 32'h0, rd);
      end
      rd_chk("work_kept", REG_WORK, 32'h0000_00a5);
      rd_chk("status_kept", REG_STATUS, 32'h0000_0003);
      // Every operation, both destinations, boundary addresses and values
      for (int i = 0; i < 100; i++) begin
         f = (i % 7 == 0) ? 0 : (i % 7 == 1) ? 127 : $urandom_range(127);
         case ($urandom_range(4))
            0: v = 8'h00;
            1: v = 8'hff;
            2: v = 8'h80;
            3: v = 8'h01;
            default: v = $urandom_range(255);
         endcase
         wr(REG_FILE_ADDR, 32'(f));
         rd_chk("file_addr", REG_FILE_ADDR, 32'(f));
         wr(REG_FILE_DATA, 32'(v));
         mem[f] = v;
         w = (i % 3 == 0) ? 0 : $urandom_range(255);
         wr(REG_WORK, 32'(w));
         st = $urandom_range(3);
         wr(REG_STATUS, 32'(st));
         c = st & 1;
         z = st >> 1;
         exec(i % 5, $urandom_range(1), f);
         rd_chk("file_data", REG_FILE_DATA, 32'(mem[f]));
         rd_chk("status_after", REG_STATUS, 32'((z << 1) | c));
      end
      // Refused op codes leave state and readback untouched
      for (int op = 5; op < 8; op++) begin
         exec(op, 1, 3);
      end
      rd_chk("instr", REG_INSTR, last_instr);
      // Reset again in mid-run
      rst();
      rd_chk("work_reset", REG_WORK, 32'h0);
      rd_chk("status_reset", REG_STATUS, 32'h0);
      rd_chk("instr_reset", REG_INSTR, 32'h0);
      stop_test();
   end

   // Watchdog on the whole run
   initial begin
      repeat (100000) @(posedge i_clk);
      n_mismatch++;
      $display("unexpected run length: expected under 100000 cycles, seen limit");
      stop_test();
   end

endmodule : tb
